// File: logic/pad_control.sv
`timescale 1ns/100ps
module pad_control #(
  parameter int WIDTH = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] data,
  input wire logic [WIDTH-1:0] direction,
  input wire logic [WIDTH-1:0] open_drain,
  input wire logic [WIDTH-1:0] pull_enable,
  input wire logic [WIDTH-1:0] pull_polarity,
  output logic [WIDTH-1:0] pad_out,
  output logic [WIDTH-1:0] pad_oe,
  output logic [WIDTH-1:0] pull_up_en,
  output logic [WIDTH-1:0] pull_down_en
);

  logic [WIDTH-1:0] od_eff;
  logic [WIDTH-1:0] pull_ok;

  // ************************************************************
  // per-pin drive and pull selection
  // ************************************************************
  assign od_eff = open_drain & direction;
  assign pull_ok = pull_enable & (~direction | od_eff);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_out <= '0;
      pad_oe <= '0;
      pull_up_en <= '0;
      pull_down_en <= '0;
    end
    else
    begin
      pad_out <= data & ~od_eff;
      pad_oe <= direction & ~(od_eff & data);
      pull_up_en <= pull_ok & ~pull_polarity;
      pull_down_en <= pull_ok & pull_polarity;
    end
  end

endmodule : pad_control

// File: logic/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // two flops; the first is read only by the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : pin_sync

// File: logic/port_m_p_io_control.sv
// Design decision made here: register access over APB.
`timescale 1ns/100ps
module port_m_p_io_control #(
  parameter int M_PINS = 6,
  parameter int P_PINS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [M_PINS-1:0] port_m_pad_in,
  output logic [M_PINS-1:0] port_m_pad_out,
  output logic [M_PINS-1:0] port_m_pad_oe,
  output logic [M_PINS-1:0] port_m_pull_up_en,
  output logic [M_PINS-1:0] port_m_pull_down_en,
  input wire logic [P_PINS-1:0] port_p_pad_in,
  output logic [P_PINS-1:0] port_p_pad_out,
  output logic [P_PINS-1:0] port_p_pad_oe,
  output logic [P_PINS-1:0] port_p_reduced_drive
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (M_PINS != port_m_p_pkg::M_WIDTH || P_PINS != port_m_p_pkg::P_WIDTH)
  begin : g_width_check
    $error("port widths must match the register layout");
  end

  // ************************************************************
  // register state
  // ************************************************************
  logic [5:0] m_pull_enable_q;
  logic [5:0] m_pull_polarity_q;
  logic [5:0] m_open_drain_q;
  logic [5:0] m_data_q;
  logic [5:0] m_direction_q;
  logic [7:0] p_data_q;
  logic [7:0] p_direction_q;
  logic [7:0] p_drive_q;
  logic [7:0] p_pin_sync;
  logic [5:0] m_pin_sync;
  logic [7:0] p_out_d;
  logic [7:0] p_oe_d;

  // ************************************************************
  // apb decode
  // ************************************************************
  logic access;
  logic wr;
  logic lane0;
  logic aligned;
  logic [7:0] idx;
  logic mapped;
  logic [31:0] rdata_d;

  assign access = psel & penable & ~pready;
  assign wr = access & pwrite;
  assign lane0 = pstrb[0];
  assign aligned = (paddr[1:0] == 2'h0);
  assign idx = {2'h0, paddr[7:2]};

  always_comb
  begin
    mapped = aligned && (paddr[11:8] == 4'h0);
    rdata_d = 32'h0000_0000;
    case (idx)
      port_m_p_pkg::IDX_M_PULL_ENABLE: rdata_d[5:0] = m_pull_enable_q;
      port_m_p_pkg::IDX_M_PULL_POLARITY: rdata_d[5:0] = m_pull_polarity_q;
      port_m_p_pkg::IDX_M_OPEN_DRAIN_MODE: rdata_d[5:0] = m_open_drain_q;
      port_m_p_pkg::IDX_M_DATA: rdata_d[5:0] = (m_direction_q & m_data_q) | (~m_direction_q & m_pin_sync);
      port_m_p_pkg::IDX_M_DIRECTION: rdata_d[5:0] = m_direction_q;
      // latch for outputs, synchronised pin level for inputs
      port_m_p_pkg::IDX_P_DATA_LATCH: rdata_d[7:0] = (p_direction_q & p_data_q) | (~p_direction_q & p_pin_sync);
      port_m_p_pkg::IDX_P_PIN_LEVELS: rdata_d[7:0] = p_pin_sync;
      port_m_p_pkg::IDX_P_DIRECTION: rdata_d[7:0] = p_direction_q;
      port_m_p_pkg::IDX_P_DRIVE_STRENGTH: rdata_d[7:0] = p_drive_q;
      default: mapped = 1'b0;
    endcase
    if (!aligned)
    begin
      mapped = 1'b0;
    end
  end

  // one wait state: pready pulses in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= access;
      pslverr <= access & ~mapped;
      if (access && !pwrite && mapped)
      begin
        prdata <= rdata_d;
      end
      else
      begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ************************************************************
  // port M control registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m_pull_enable_q <= port_m_p_pkg::RST_M_PULL_ENABLE;
      m_pull_polarity_q <= port_m_p_pkg::RST_M_PULL_POLARITY;
      m_open_drain_q <= port_m_p_pkg::RST_M_OPEN_DRAIN;
      m_data_q <= port_m_p_pkg::RST_M_DATA;
      m_direction_q <= port_m_p_pkg::RST_M_DIRECTION;
    end
    // refused addresses (upper page, misaligned) must not alias onto a register
    else if (wr && lane0 && mapped)
    begin
      case (idx)
        port_m_p_pkg::IDX_M_PULL_ENABLE: m_pull_enable_q <= pwdata[5:0];
        port_m_p_pkg::IDX_M_PULL_POLARITY: m_pull_polarity_q <= pwdata[5:0];
        port_m_p_pkg::IDX_M_OPEN_DRAIN_MODE: m_open_drain_q <= pwdata[5:0];
        port_m_p_pkg::IDX_M_DATA: m_data_q <= pwdata[5:0];
        port_m_p_pkg::IDX_M_DIRECTION: m_direction_q <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // port P control registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      p_data_q <= port_m_p_pkg::RST_P_DATA;
      p_direction_q <= port_m_p_pkg::RST_P_DIRECTION;
      p_drive_q <= port_m_p_pkg::RST_P_DRIVE;
    end
    else if (wr && lane0 && mapped)
    begin
      case (idx)
        port_m_p_pkg::IDX_P_DATA_LATCH: p_data_q <= pwdata[7:0];
        port_m_p_pkg::IDX_P_DIRECTION: p_direction_q <= pwdata[7:0];
        port_m_p_pkg::IDX_P_DRIVE_STRENGTH: p_drive_q <= pwdata[7:0];
        // pin level register has no storage; writes fall through
        port_m_p_pkg::IDX_P_PIN_LEVELS: ;
        default: ;
      endcase
    end
  end

  // ************************************************************
  // pin input synchronisers
  // ************************************************************
  pin_sync #(
    .WIDTH(P_PINS)
  ) u_sync_p (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(port_p_pad_in),
    .sync_out(p_pin_sync)
  );

  pin_sync #(
    .WIDTH(M_PINS)
  ) u_sync_m (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(port_m_pad_in),
    .sync_out(m_pin_sync)
  );

  // ************************************************************
  // port M pad drive
  // ************************************************************
  pad_control #(
    .WIDTH(M_PINS)
  ) u_pad_m (
    .pclk(pclk),
    .presetn(presetn),
    .data(m_data_q),
    .direction(m_direction_q),
    .open_drain(m_open_drain_q),
    .pull_enable(m_pull_enable_q),
    .pull_polarity(m_pull_polarity_q),
    .pad_out(port_m_pad_out),
    .pad_oe(port_m_pad_oe),
    .pull_up_en(port_m_pull_up_en),
    .pull_down_en(port_m_pull_down_en)
  );

  // ************************************************************
  // port P pad drive
  // ************************************************************
  assign p_out_d = p_data_q;
  assign p_oe_d = p_direction_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_p_pad_out <= port_m_p_pkg::RST_P_DATA;
      port_p_pad_oe <= port_m_p_pkg::RST_P_DIRECTION;
      port_p_reduced_drive <= port_m_p_pkg::RST_P_DRIVE;
    end
    else
    begin
      port_p_pad_out <= p_out_d;
      port_p_pad_oe <= p_oe_d;
      port_p_reduced_drive <= p_drive_q & p_direction_q;
    end
  end

endmodule : port_m_p_io_control

// File: logic/port_m_p_pkg.sv
package port_m_p_pkg;

  // ************************************************************
  // register offsets (printed offsets are not all multiples of four: index x4)
  // ************************************************************
  localparam logic [7:0] IDX_M_PULL_ENABLE = 8'h14;
  localparam logic [7:0] IDX_M_PULL_POLARITY = 8'h15;
  localparam logic [7:0] IDX_M_OPEN_DRAIN_MODE = 8'h16;
  localparam logic [7:0] IDX_P_DATA_LATCH = 8'h18;
  localparam logic [7:0] IDX_P_PIN_LEVELS = 8'h19;
  localparam logic [7:0] IDX_P_DIRECTION = 8'h1A;
  localparam logic [7:0] IDX_P_DRIVE_STRENGTH = 8'h1B;
  // port M pin-side controls that no printed register holds
  localparam logic [7:0] IDX_M_DATA = 8'h20;
  localparam logic [7:0] IDX_M_DIRECTION = 8'h21;

  localparam int M_WIDTH = 6;
  localparam int P_WIDTH = 8;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [5:0] RST_M_PULL_ENABLE = 6'h3F;
  localparam logic [5:0] RST_M_PULL_POLARITY = 6'h00;
  localparam logic [5:0] RST_M_OPEN_DRAIN = 6'h00;
  localparam logic [5:0] RST_M_DATA = 6'h00;
  localparam logic [5:0] RST_M_DIRECTION = 6'h00;
  localparam logic [7:0] RST_P_DATA = 8'h00;
  localparam logic [7:0] RST_P_DIRECTION = 8'h00;
  localparam logic [7:0] RST_P_DRIVE = 8'h00;

  // ************************************************************
  // synchroniser depth on pin inputs
  // ************************************************************
  localparam int SYNC_STAGES = 2;

endpackage : port_m_p_pkg

// File: tb/pad_model.sv
`timescale 1ns/100ps
module pad_model #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic [W-1:0] pad_out,
  input wire logic [W-1:0] pad_oe,
  input wire logic [W-1:0] pull_up,
  input wire logic [W-1:0] pull_down,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pad_in
);
  // ****
  // pin level: outside driver wins, then pad, then pull, else floating
  // ****
  logic [W-1:0] float_q = '0;
  always_ff @(posedge pclk)
    float_q <= ~float_q;
  always_comb
    for (int i = 0; i < W; i++)
      if (ext_en[i])
        pad_in[i] = ext_val[i];
      else if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (pull_up[i] | pull_down[i])
        pad_in[i] = pull_up[i];
      else
        pad_in[i] = float_q[i];
endmodule : pad_model

// File: tb/port_m_p_io_control_chk.sv
`timescale 1ns/100ps
module io_chk #(
  parameter int M_PINS = 6,
  parameter int P_PINS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [M_PINS-1:0] port_m_pad_out,
  input wire logic [M_PINS-1:0] port_m_pad_oe,
  input wire logic [M_PINS-1:0] port_m_pull_up_en,
  input wire logic [M_PINS-1:0] port_m_pull_down_en,
  input wire logic [P_PINS-1:0] port_p_pad_out,
  input wire logic [P_PINS-1:0] port_p_pad_oe,
  input wire logic [P_PINS-1:0] port_p_reduced_drive
);
  // ****
  // bus and pin relations
  // ****
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_wr(a);
    psel && penable && !pready && pwrite && pstrb[0] && paddr == a;
  endsequence
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_ready_answer: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  a_err_high: assert property (pready && paddr[11:8] != 4'h0 |-> pslverr) else $error("no pslverr");
  a_p_dir_oe: assert property (s_wr(12'h068) |=> ##1 port_p_pad_oe == $past(pwdata, 2))
    else $error("oe differs from direction");
  a_p_latch_out: assert property (s_wr(12'h060) |=> ##1 port_p_pad_out == $past(pwdata, 2))
    else $error("pad out differs from latch");
  a_p_reduced_in: assert property ((port_p_reduced_drive & ~port_p_pad_oe) == '0)
    else $error("reduced drive on input");
  a_m_pull_pushpull: assert property (((port_m_pull_up_en | port_m_pull_down_en) & port_m_pad_oe & port_m_pad_out) == '0)
    else $error("pull on push-pull output");
  a_m_pull_excl: assert property ((port_m_pull_up_en & port_m_pull_down_en) == '0)
    else $error("pull up and down together");
  a_m_reset_up: assert property ($rose(presetn) |=> port_m_pull_up_en == 6'h3F)
    else $error("pull-ups not on after reset");
endmodule : io_chk

bind port_m_p_io_control io_chk #(.M_PINS(M_PINS), .P_PINS(P_PINS)) u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .port_m_pad_out, .port_m_pad_oe, .port_m_pull_up_en,
  .port_m_pull_down_en, .port_p_pad_out, .port_p_pad_oe, .port_p_reduced_drive);

// File: tb/port_m_p_io_control_tb.sv
`timescale 1ns/100ps
module port_m_p_io_control_tb;
  // ****
  // signals and instances
  // ****
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] m_in, m_out, m_oe, m_up, m_dn;
  logic [7:0] p_in, p_out, p_oe, p_rd;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [3:0] strb = 4'hF;
  logic [5:0] m_ext_en = 6'h00;
  logic [5:0] m_ext_val = 6'h00;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #12.5 pclk = ~pclk;
  port_m_p_io_control u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(strb),
    .prdata, .pready, .pslverr, .port_m_pad_in(m_in), .port_m_pad_out(m_out), .port_m_pad_oe(m_oe),
    .port_m_pull_up_en(m_up), .port_m_pull_down_en(m_dn), .port_p_pad_in(p_in), .port_p_pad_out(p_out),
    .port_p_pad_oe(p_oe), .port_p_reduced_drive(p_rd));
  pad_model #(.W(6)) u_pad_m (.pclk, .pad_out(m_out), .pad_oe(m_oe), .pull_up(m_up), .pull_down(m_dn),
    .ext_en(m_ext_en), .ext_val(m_ext_val), .pad_in(m_in));
  pad_model #(.W(8)) u_pad_p (.pclk, .pad_out(p_out), .pad_oe(p_oe), .pull_up(8'h00), .pull_down(8'h00),
    .ext_en, .ext_val, .pad_in(p_in));
  // ****
  // tasks
  // ****
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic t_reset;
    apb(1'b0, 12'h050, 32'h0);
    chk(rd, 32'h3F);
    apb(1'b0, 12'h054, 32'h0);
    chk(rd, 32'h00);
    chk({26'h0, m_up}, 32'h3F);
    $display("reset test done");
  endtask : t_reset
  task automatic t_port_p;
    ext_en <= 8'h8F;
    ext_val <= 8'h06;
    apb(1'b1, 12'h068, 32'hF0);
    apb(1'b1, 12'h060, 32'hA5);
    apb(1'b1, 12'h06C, 32'hFF);
    chk({8'h0, p_oe, p_out, p_rd}, 32'h00F0A5F0);
    apb(1'b0, 12'h060, 32'h0);
    chk(rd, 32'hA6);
    apb(1'b0, 12'h064, 32'h0);
    chk(rd, 32'h26);
    apb(1'b1, 12'h064, 32'hFF);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, 12'h068, 32'h0);
    chk(rd, 32'hF0);
    ext_en <= 8'hF0;
    ext_val <= 8'h50;
    apb(1'b1, 12'h068, 32'h0F);
    repeat (2) @(posedge pclk);
    apb(1'b0, 12'h060, 32'h0);
    chk(rd, 32'h55);
    chk({24'h0, p_rd}, 32'h0F);
    $display("port p test done");
  endtask : t_port_p
  task automatic t_port_m;
    m_ext_en <= 6'h30;
    m_ext_val <= 6'h20;
    apb(1'b1, 12'h084, 32'h0F);
    apb(1'b1, 12'h080, 32'h05);
    apb(1'b1, 12'h058, 32'h33);
    apb(1'b1, 12'h054, 32'h2A);
    chk({2'h0, m_up, 2'h0, m_dn, 2'h0, m_oe, 2'h0, m_out}, 32'h11220E04);
    apb(1'b1, 12'h050, 32'h3C);
    chk({18'h0, m_up, 2'h0, m_dn}, 32'h1020);
    apb(1'b0, 12'h080, 32'h0);
    chk(rd, 32'h25);
    $display("port m test done");
  endtask : t_port_m
  task automatic t_refuse;
    apb(1'b0, 12'h074, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h150, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h051, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    strb <= 4'hE;
    apb(1'b1, 12'h050, 32'h0);
    strb <= 4'hF;
    chk({31'h0, err}, 32'h0);
    apb(1'b0, 12'h050, 32'h0);
    chk(rd, 32'h3C);
    $display("refusal test done");
  endtask : t_refuse
  // ****
  // sequence and timeout
  // ****
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      test_done();
    end
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_port_p();
    t_port_m();
    t_refuse();
    test_done();
  end
endmodule : port_m_p_io_control_tb
